// ### design/ieb_pkg.sv
// Purpose: shared constants and types of the interrupt enable bank
// Assumes: 16-bit registers on a plain strobe port, one clock
// Notes: bank index 0, 1, 2 stands for enable registers one, two, three

package ieb_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NREG = 3;
	localparam int DW = 16;
	localparam int AW = 4;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [3:0] OFS_EN_ONE = 4'h0;
	localparam logic [3:0] OFS_EN_TWO = 4'h1;
	localparam logic [3:0] OFS_EN_THREE = 4'h2;
	localparam logic [3:0] OFS_FLAG_ONE = 4'h3;
	localparam logic [3:0] OFS_FLAG_TWO = 4'h4;
	localparam logic [3:0] OFS_FLAG_THREE = 4'h5;

	// ****************************************
	// reset values and implemented-bit masks
	// ****************************************
	localparam logic [15:0] EN_RST = 16'h0000;
	localparam logic [15:0] FLAG_RST = 16'h0000;
	localparam logic [15:0] IMPL_ONE = 16'h0003;
	localparam logic [15:0] IMPL_TWO = 16'h67FF;
	localparam logic [15:0] IMPL_THREE = 16'h7DE6;

	// ****************************************
	// field positions, enable register one
	// ****************************************
	localparam int BIT_I2C1_MASTER = 1;
	localparam int BIT_I2C1_SLAVE = 0;

	// ****************************************
	// field positions, enable register two
	// ****************************************
	localparam int BIT_DMA_FOUR = 14;
	localparam int BIT_PAR_PORT = 13;
	localparam int BIT_CMP_SIX = 10;
	localparam int BIT_CMP_FIVE = 9;
	localparam int BIT_CAP_SIX = 8;
	localparam int BIT_CAP_FIVE = 7;
	localparam int BIT_CAP_FOUR = 6;
	localparam int BIT_CAP_THREE = 5;
	localparam int BIT_DMA_THREE = 4;
	localparam int BIT_CRY_ROLL = 3;
	localparam int BIT_CRY_FREE = 2;
	localparam int BIT_SPI2_TX = 1;
	localparam int BIT_SPI2_GEN = 0;

	// ****************************************
	// field positions, enable register three
	// ****************************************
	localparam int BIT_CALENDAR = 14;
	localparam int BIT_DMA_FIVE = 13;
	localparam int BIT_SPI3_RX = 12;
	localparam int BIT_SPI2_RX = 11;
	localparam int BIT_SPI1_RX = 10;
	localparam int BIT_KEY_DONE = 8;
	localparam int BIT_CRY_DONE = 7;
	localparam int BIT_EXT_FOUR = 6;
	localparam int BIT_EXT_THREE = 5;
	localparam int BIT_I2C2_MASTER = 2;
	localparam int BIT_I2C2_SLAVE = 1;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} ieb_bus_t;

	typedef logic [2:0][15:0] ieb_bank_t;

endpackage

// ### design/ieb_top.sv
// Purpose: interrupt enable bank with sticky source flags and gating
// Assumes: sources raise one-cycle event pulses synchronous to clk
// Notes: flag bits are cleared by writing one; a new event wins
//
// Summary of operation
// [R1] Each enable bit passes its source when one and blocks it when zero; bits 1 and 0 of enable one gate the I2C1 master and slave events.
// [R2] Software that enables an external pin interrupt must also route that input to a remappable pin through the pin select logic.
// [R3] Bits 15, 12 and 11 of enable two read as zero and ignore writes.
// [R4] Enable two bits 14, 13, 10, 9 and 8 gate DMA 4, the parallel port, compare 6, compare 5 and capture 6.
// [R5] Enable two bits 7, 6, 5 and 4 gate capture 5, 4, 3 and DMA 3.
// [R6] Enable two bits 3 and 2 gate the crypto rollover and buffer free events.
// [R7] Enable two bits 1 and 0 gate the SPI2 transmit and general events.
// [R8] Enable three bits 14 and 13 gate the calendar and DMA 5, bit 15 reads zero.
// [R9] Enable three bits 12, 11, 10 and 8 gate SPI3, SPI2, SPI1 receive and key store done, bit 9 reads zero.
// [R10] Enable three bits 7, 6, 5, 2 and 1 gate crypto done, external 4 and 3, I2C2 master and slave, bits 4, 3, 0 read zero.
// [R11] Every implemented enable bit is read/write and clears to zero at reset.
// [R12] A request goes onward only while its flag and its enable are both set.

`timescale 1ns/1ps

module ieb_top
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire ieb_pkg::ieb_bus_t bus_req,
	output logic [15:0] rd_data,
	// interrupt sources and gated requests
	input wire ieb_pkg::ieb_bank_t src_evt,
	output ieb_pkg::ieb_bank_t req_out,
	output logic irq
);

	// ****************************************
	// state
	// ****************************************
	ieb_pkg::ieb_bank_t en_q;
	ieb_pkg::ieb_bank_t en_d;
	ieb_pkg::ieb_bank_t flag_q;
	ieb_pkg::ieb_bank_t flag_d;
	ieb_pkg::ieb_bank_t req_q;
	ieb_pkg::ieb_bank_t req_d;
	logic irq_q;
	logic irq_d;
	logic [15:0] rd_q;
	logic [15:0] rd_d;
	ieb_pkg::ieb_bank_t impl;

	assign impl[0] = ieb_pkg::IMPL_ONE;
	assign impl[1] = ieb_pkg::IMPL_TWO;
	assign impl[2] = ieb_pkg::IMPL_THREE;

	// ****************************************
	// enable and flag registers, one per bank
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < ieb_pkg::NREG; g++)
		begin : g_bank
			logic en_hit;
			logic flag_hit;

			assign en_hit = bus_req.wr &&
				(bus_req.addr == ieb_pkg::OFS_EN_ONE + 4'(g));
			assign flag_hit = bus_req.wr &&
				(bus_req.addr == ieb_pkg::OFS_FLAG_ONE + 4'(g));

			always_comb
			begin
				// unimplemented positions never store a one
				en_d[g] = en_q[g]; // [R3] [R8] [R9] [R10]
				if (en_hit)
				begin
					en_d[g] = bus_req.wdata & impl[g]; // [R11]
				end
				// write one clears, a fresh event wins over the clear
				flag_d[g] = flag_q[g];
				if (flag_hit)
				begin
					flag_d[g] = flag_q[g] & ~bus_req.wdata;
				end
				flag_d[g] = flag_d[g] | (src_evt[g] & impl[g]);
				// source passes only while flag and enable are set
				req_d[g] = flag_q[g] & en_q[g]; // [R1] [R4] [R5] [R6] [R7] [R12]
			end

			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					en_q[g] <= ieb_pkg::EN_RST; // [R11]
					flag_q[g] <= ieb_pkg::FLAG_RST;
					req_q[g] <= 16'h0000;
				end
				else
				begin
					en_q[g] <= en_d[g];
					flag_q[g] <= flag_d[g];
					req_q[g] <= req_d[g];
				end
			end
		end
	endgenerate

	// ****************************************
	// interrupt line and read port
	// ****************************************
	always_comb
	begin
		irq_d = |(flag_q & en_q); // [R12]
		rd_d = 16'h0000;
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				ieb_pkg::OFS_EN_ONE: rd_d = en_q[0]; // [R11]
				ieb_pkg::OFS_EN_TWO: rd_d = en_q[1]; // [R11]
				ieb_pkg::OFS_EN_THREE: rd_d = en_q[2]; // [R11]
				ieb_pkg::OFS_FLAG_ONE: rd_d = flag_q[0];
				ieb_pkg::OFS_FLAG_TWO: rd_d = flag_q[1];
				ieb_pkg::OFS_FLAG_THREE: rd_d = flag_q[2];
				default: rd_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_q <= 1'b0;
			rd_q <= 16'h0000;
		end
		else
		begin
			irq_q <= irq_d;
			rd_q <= rd_d;
		end
	end

	assign rd_data = rd_q;
	assign req_out = req_q;
	assign irq = irq_q;

	// ****************************************
	// checks
	// ****************************************
	logic wr_en1;
	logic wr_en2;
	logic wr_en3;
	logic woke_q;

	assign wr_en1 = bus_req.wr && (bus_req.addr == ieb_pkg::OFS_EN_ONE);
	assign wr_en2 = bus_req.wr && (bus_req.addr == ieb_pkg::OFS_EN_TWO);
	assign wr_en3 = bus_req.wr && (bus_req.addr == ieb_pkg::OFS_EN_THREE);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			woke_q <= 1'b0;
		end
		else
		begin
			woke_q <= 1'b1;
		end
	end

	property p_en_one_gate;
		@(posedge clk) disable iff (!nrst)
		wr_en1 ##1 (flag_q[0][ieb_pkg::BIT_I2C1_MASTER] && !bus_req.wr)
		|=> req_out[0][ieb_pkg::BIT_I2C1_MASTER] ==
			$past(bus_req.wdata[ieb_pkg::BIT_I2C1_MASTER], 2);
	endproperty
	a_en_one_gate: assert property (p_en_one_gate) // [R1]
		else $error("i2c1 master request does not follow its enable");

	property p_two_unimpl;
		@(posedge clk) disable iff (!nrst)
		wr_en2 |=> en_q[1][15] == 1'b0 && en_q[1][12:11] == 2'b00;
	endproperty
	a_two_unimpl: assert property (p_two_unimpl) // [R3]
		else $error("unimplemented enable two bit took a write");

	property p_two_high;
		@(posedge clk) disable iff (!nrst)
		wr_en2 |=> en_q[1][ieb_pkg::BIT_DMA_FOUR] ==
			$past(bus_req.wdata[14]) && en_q[1][10:8] ==
			$past(bus_req.wdata[10:8]) && en_q[1][ieb_pkg::BIT_PAR_PORT] ==
			$past(bus_req.wdata[13]);
	endproperty
	a_two_high: assert property (p_two_high) // [R4]
		else $error("enable two upper fields not stored");

	property p_two_mid;
		@(posedge clk) disable iff (!nrst)
		wr_en2 ##1 (!bus_req.wr && !bus_req.rd) |=> rd_data == 16'h0000 &&
			en_q[1][7:4] == $past(bus_req.wdata[7:4], 2);
	endproperty
	a_two_mid: assert property (p_two_mid) // [R5]
		else $error("capture and dma three enables not stored");

	property p_two_crypto;
		@(posedge clk) disable iff (!nrst)
		wr_en2 |=> en_q[1][ieb_pkg::BIT_CRY_ROLL] == $past(bus_req.wdata[3])
			&& en_q[1][ieb_pkg::BIT_CRY_FREE] == $past(bus_req.wdata[2]);
	endproperty
	a_two_crypto: assert property (p_two_crypto) // [R6]
		else $error("crypto enables not stored");

	property p_two_spi;
		@(posedge clk) disable iff (!nrst)
		wr_en2 ##1 bus_req.rd && bus_req.addr == ieb_pkg::OFS_EN_TWO
		|=> rd_data[1:0] == $past(bus_req.wdata[1:0], 2);
	endproperty
	a_two_spi: assert property (p_two_spi) // [R7]
		else $error("spi2 enables do not read back");

	property p_three_high;
		@(posedge clk) disable iff (!nrst)
		wr_en3 |=> en_q[2][15] == 1'b0 &&
			en_q[2][ieb_pkg::BIT_CALENDAR] == $past(bus_req.wdata[14]) &&
			en_q[2][ieb_pkg::BIT_DMA_FIVE] == $past(bus_req.wdata[13]);
	endproperty
	a_three_high: assert property (p_three_high) // [R8]
		else $error("calendar or dma five enable wrong");

	property p_three_mid;
		@(posedge clk) disable iff (!nrst)
		wr_en3 |=> en_q[2][9] == 1'b0 &&
			en_q[2][12:10] == $past(bus_req.wdata[12:10]) &&
			en_q[2][ieb_pkg::BIT_KEY_DONE] == $past(bus_req.wdata[8]);
	endproperty
	a_three_mid: assert property (p_three_mid) // [R9]
		else $error("spi receive or key store enable wrong");

	property p_three_low;
		@(posedge clk) disable iff (!nrst)
		wr_en3 |=> en_q[2][7:0] == ($past(bus_req.wdata[7:0]) & 8'hE6);
	endproperty
	a_three_low: assert property (p_three_low) // [R10]
		else $error("enable three low byte wrong");

	property p_reset_clear;
		@(posedge clk) disable iff (!nrst)
		!woke_q |-> en_q == '0 && req_out == '0 && !irq;
	endproperty
	a_reset_clear: assert property (p_reset_clear) // [R11]
		else $error("enables not clear after reset");

	property p_event_to_irq;
		@(posedge clk) disable iff (!nrst)
		(|(src_evt & en_q) && !bus_req.wr) ##1 !bus_req.wr |=> irq;
	endproperty
	a_event_to_irq: assert property (p_event_to_irq) // [R12]
		else $error("enabled event did not raise the interrupt");

	property p_no_en_no_req;
		@(posedge clk) disable iff (!nrst)
		(en_q == '0) ##1 1'b1 |-> req_out == '0 && !irq;
	endproperty
	a_no_en_no_req: assert property (p_no_en_no_req) // [R12]
		else $error("request passed with all enables clear");

	property p_set_wins;
		@(posedge clk) disable iff (!nrst)
		bus_req.wr && bus_req.addr == ieb_pkg::OFS_FLAG_TWO &&
			src_evt[1][ieb_pkg::BIT_DMA_THREE]
		|=> flag_q[1][ieb_pkg::BIT_DMA_THREE];
	endproperty
	a_set_wins: assert property (p_set_wins) // [R12]
		else $error("event lost to a flag clear in the same cycle");

	property p_rd_idle;
		@(posedge clk) disable iff (!nrst)
		!bus_req.rd |=> rd_data == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) // [R11]
		else $error("read data not zero outside a read answer");

	property p_two_rd_zero;
		@(posedge clk) disable iff (!nrst)
		bus_req.rd && bus_req.addr == ieb_pkg::OFS_EN_TWO
		|=> (rd_data & ~ieb_pkg::IMPL_TWO) == 16'h0000;
	endproperty
	a_two_rd_zero: assert property (p_two_rd_zero) // [R3]
		else $error("unimplemented enable two bit read as one");

	property p_unmapped_wr;
		@(posedge clk) disable iff (!nrst)
		bus_req.wr && bus_req.addr > ieb_pkg::OFS_FLAG_THREE
		|=> en_q == $past(en_q);
	endproperty
	a_unmapped_wr: assert property (p_unmapped_wr) // [R11]
		else $error("write to an unmapped index changed an enable");

	c_write_two: cover property (@(posedge clk) disable iff (!nrst)
		wr_en2 ##1 en_q[1] != 16'h0000);
	c_irq_rise: cover property (@(posedge clk) disable iff (!nrst)
		$rose(irq));
	c_set_and_clear: cover property (@(posedge clk) disable iff (!nrst)
		bus_req.wr && bus_req.addr == ieb_pkg::OFS_FLAG_TWO &&
		|(src_evt[1] & bus_req.wdata));
	c_read_three: cover property (@(posedge clk) disable iff (!nrst)
		bus_req.rd && bus_req.addr == ieb_pkg::OFS_EN_THREE ##1
		rd_data != 16'h0000);

endmodule

// ### testbench/ieb_tb.sv
// Purpose: self-checking bench of the interrupt enable bank
// Assumes: bus, sources and reset timing as in the design hand-over
// Notes: xorshift stimulus, fixed start value, bench model of the state

`timescale 1ns/1ps

module testbench;

	// ****************************************
	// signals and bench state
	// ****************************************
	logic clk;
	logic nrst;
	ieb_pkg::ieb_bus_t bus_req;
	logic [15:0] rd_data;
	ieb_pkg::ieb_bank_t src_evt;
	ieb_pkg::ieb_bank_t req_out;
	logic irq;
	int num_errors;
	int checks_done;
	int cycles;
	logic [31:0] seed;
	logic [15:0] en_m [3];
	logic [15:0] fl_m [3];

	ieb_top dut
	(
		.clk(clk),
		.nrst(nrst),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.src_evt(src_evt),
		.req_out(req_out),
		.irq(irq)
	);

	always #12.5 clk = ~clk;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [15:0] impl(int i);
		case (i)
			0: return ieb_pkg::IMPL_ONE;
			1: return ieb_pkg::IMPL_TWO;
			default: return ieb_pkg::IMPL_THREE;
		endcase
	endfunction

	function automatic logic [15:0] exp_reg(int a);
		if (a < 3)
			return en_m[a];
		else if (a < 6)
			return fl_m[a - 3];
		return 16'h0000;
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(int a, logic [15:0] d);
		@(posedge clk);
		bus_req <= ieb_pkg::ieb_bus_t'{wr:1'b1, rd:1'b0, addr:4'(a), wdata:d};
		@(posedge clk);
		bus_req <= '0;
		if (a < 3)
			en_m[a] = d & impl(a);
		else if (a < 6)
			fl_m[a - 3] &= ~d;
	endtask

	task automatic rd(int a);
		@(posedge clk);
		bus_req <= ieb_pkg::ieb_bus_t'{wr:1'b0, rd:1'b1, addr:4'(a),
			wdata:16'h0000};
		@(posedge clk);
		bus_req <= '0;
		#1 chk("rd_data", exp_reg(a), rd_data);
		@(posedge clk);
		#1 chk("rd_idle", 16'h0000, rd_data);
	endtask

	// enable write followed at once by its read back
	task automatic wr_rd(int a, logic [15:0] d);
		@(posedge clk);
		bus_req <= ieb_pkg::ieb_bus_t'{wr:1'b1, rd:1'b0, addr:4'(a), wdata:d};
		@(posedge clk);
		bus_req <= ieb_pkg::ieb_bus_t'{wr:1'b0, rd:1'b1, addr:4'(a),
			wdata:16'h0000};
		en_m[a] = d & impl(a);
		@(posedge clk);
		bus_req <= '0;
		#1 chk("rd_back", exp_reg(a), rd_data);
	endtask

	// gated outputs against flag and enable of the model
	task automatic check_out();
		logic any;
		any = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			chk("req_out", fl_m[i] & en_m[i], req_out[i]);
			any |= |(fl_m[i] & en_m[i]);
		end
		chk("irq", {15'h0000, any}, {15'h0000, irq});
	endtask

	task automatic pulse(ieb_pkg::ieb_bank_t v);
		@(posedge clk);
		src_evt <= v;
		@(posedge clk);
		src_evt <= '0;
		for (int i = 0; i < 3; i++)
			fl_m[i] |= v[i] & impl(i);
		@(posedge clk);
		#1 check_out();
	endtask

	// flag clear and fresh events in one cycle, the events must stay
	task automatic clr_evt(int i, logic [15:0] d);
		@(posedge clk);
		bus_req <= ieb_pkg::ieb_bus_t'{wr:1'b1, rd:1'b0, addr:4'(i + 3),
			wdata:16'hFFFF};
		src_evt[i] <= d;
		@(posedge clk);
		bus_req <= '0;
		src_evt <= '0;
		fl_m[i] = d & impl(i);
		@(posedge clk);
		#1 check_out();
	endtask

	// ****************************************
	// timeout
	// ****************************************
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			$display("mismatch timeout expected finish seen hang");
			stop_test();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		bus_req = '0;
		src_evt = '0;
		num_errors = 0;
		checks_done = 0;
		cycles = 0;
		seed = 32'h0000EB8C;
		for (int i = 0; i < 3; i++)
		begin
			en_m[i] = 16'h0000;
			fl_m[i] = 16'h0000;
		end
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		// reset values, unmapped index included
		for (int a = 0; a < 8; a++)
			rd(a);
		#1 check_out();
		$display("test reset done");
		// all ones and all zeros written to every enable
		for (int a = 0; a < 3; a++)
		begin
			wr(a, 16'hFFFF);
			rd(a);
			wr(a, 16'h0000);
			rd(a);
		end
		wr(9, 16'hFFFF);
		rd(9);
		for (int a = 0; a < 3; a++)
			wr_rd(a, 16'(rnd()));
		$display("test access done");
		// each enable bit alone against all sources of its own bank firing
		for (int i = 0; i < 3; i++)
			for (int b = 0; b < 16; b++)
			begin
				ieb_pkg::ieb_bank_t v;
				v = '0;
				v[i] = 16'hFFFF;
				wr(i, 16'h0001 << b);
				pulse(v);
				rd(i + 3);
				wr(i + 3, 16'hFFFF);
				@(posedge clk);
				#1 check_out();
			end
		wr(1, ieb_pkg::IMPL_TWO);
		clr_evt(1, 16'hFFFF);
		wr(4, 16'hFFFF);
		wr(1, 16'h0000);
		$display("test gating done");
		// random traffic over registers and sources
		for (int n = 0; n < 200; n++)
		begin
			ieb_pkg::ieb_bank_t v;
			int a;
			a = int'(rnd() % 8);
			wr(a, 16'(rnd()));
			rd(int'(rnd() % 8));
			v = '0;
			v[rnd() % 3] = 16'(rnd() & rnd());
			pulse(v);
		end
		$display("test random done");
		stop_test();
	end

endmodule
